//--- core/hbad_device.sv
// Device end: decodes host bus transfers and serves reads and writes
//
// Behaviour
// R01: Strobe mode read: select low status, high data.
// R02: Write: select low data/parameter, high command.
// R03: Enable mode: read/write line high reads, low writes.
// R04: Read strobe active low gates bus drivers.
// R05: Enable clock active high; transfer while high.
// R06: Write strobe active low; data taken on edge.
// R07: Respond only while chip select low.
// R08: Hardware clear low resets transfer phase and captured data; mode and clear flag still follow the pins.
// R09: Family selects: 00 strobe, 10 enable mode.
// R10: Latch data and select on write strobe rise.
`default_nettype none
module hbad_device #(
  parameter int DATA_W = hbad_pkg::DATA_W
) (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Pins
  hbad_if.device bus,
  // Read sources
  input wire logic [DATA_W-1:0] i_status,
  input wire logic [DATA_W-1:0] i_rd_data,
  // Write sink
  output logic o_wr_valid,
  output logic o_wr_is_cmd,
  output logic [DATA_W-1:0] o_wr_data,
  // Read completion
  output logic o_rd_ack,
  output logic o_rd_was_data,
  // Status
  output logic o_hw_clear,
  output logic [1:0] o_mode
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (DATA_W != hbad_pkg::DATA_W) begin : g_bad_width
    $error("hbad_device: DATA_W must match the pin bus width");
  end

  localparam int PIN_W = DATA_W + 7;
  localparam int P_CS = 0;
  localparam int P_DTS = 1;
  localparam int P_RD = 2;
  localparam int P_WR = 3;
  localparam int P_SA = 4;
  localparam int P_SB = 5;
  localparam int P_CLR = 6;
  localparam int P_DAT = 7;
  localparam logic [PIN_W-1:0] PIN_RESET = {hbad_pkg::BUS_IDLE, 7'h4D};

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_READ = 2'h1,
    PH_WRITE = 2'h2
  } hbad_phase_type;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic hbad_pkg::hbad_mode_type mode_of(input logic sel_a, input logic sel_b);
    hbad_pkg::hbad_mode_type m;
    m = hbad_pkg::MODE_NONE;
    if (!sel_a && !sel_b) begin
      m = hbad_pkg::MODE_STROBE; // R09
    end else if (sel_a && !sel_b) begin
      m = hbad_pkg::MODE_ENABLE; // R09
    end
    return m;
  endfunction

  function automatic hbad_pkg::hbad_xfer_type kind_of(input hbad_pkg::hbad_mode_type m, input logic [PIN_W-1:0] p);
    hbad_pkg::hbad_xfer_type k;
    logic rd;
    logic wr;
    k = hbad_pkg::XFER_NONE;
    rd = 1'b0;
    wr = 1'b0;
    case (m)
      hbad_pkg::MODE_STROBE: begin
        // Both strobes low together is illegal and is ignored
        rd = !p[P_RD] && p[P_WR]; // R04
        wr = !p[P_WR] && p[P_RD]; // R06
      end
      hbad_pkg::MODE_ENABLE: begin
        rd = p[P_RD] && p[P_WR]; // R03 R05
        wr = p[P_RD] && !p[P_WR]; // R03 R05
      end
      default: begin
        rd = 1'b0;
        wr = 1'b0;
      end
    endcase
    if (!p[P_CS]) begin // R07
      if (rd) begin
        k = p[P_DTS] ? hbad_pkg::XFER_DATA_RD : hbad_pkg::XFER_STATUS_RD; // R01 R03
      end else if (wr) begin
        k = p[P_DTS] ? hbad_pkg::XFER_CMD_WR : hbad_pkg::XFER_PARAM_WR; // R02
      end
    end
    return k;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] sync2_reg;
  logic [PIN_W-1:0] prev_reg;

  assign pin_raw = {bus.data_bus, bus.hardware_clear_n, bus.host_family_select_b,
    bus.host_family_select_a, bus.write_or_rw, bus.read_or_enable,
    bus.data_type_select, bus.chip_select_n};

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_reg <= PIN_RESET;
      sync2_reg <= PIN_RESET;
      prev_reg <= PIN_RESET;
    end else if (i_ce) begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Transfer phase and outputs
  // ----------------------------------------------------------------
  hbad_pkg::hbad_mode_type mode_now;
  hbad_pkg::hbad_xfer_type kind_now;
  hbad_pkg::hbad_xfer_type kind_prev;
  logic clear_now;

  hbad_phase_type phase_reg;
  hbad_phase_type phase_next;
  logic wr_valid_reg;
  logic wr_valid_next;
  logic wr_is_cmd_reg;
  logic wr_is_cmd_next;
  logic [DATA_W-1:0] wr_data_reg;
  logic [DATA_W-1:0] wr_data_next;
  logic rd_ack_reg;
  logic rd_ack_next;
  logic rd_was_data_reg;
  logic rd_was_data_next;
  logic [DATA_W-1:0] dout_reg;
  logic [DATA_W-1:0] dout_next;
  logic doe_reg;
  logic doe_next;
  logic clear_reg;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;

  assign mode_now = mode_of(sync2_reg[P_SA], sync2_reg[P_SB]);
  assign kind_now = kind_of(mode_now, sync2_reg);
  assign kind_prev = kind_of(mode_now, prev_reg);
  assign clear_now = !sync2_reg[P_CLR];

  always_comb begin
    phase_next = phase_reg;
    wr_valid_next = 1'b0;
    wr_is_cmd_next = wr_is_cmd_reg;
    wr_data_next = wr_data_reg;
    rd_ack_next = 1'b0;
    rd_was_data_next = rd_was_data_reg;
    dout_next = dout_reg;
    doe_next = 1'b0;
    mode_next = mode_now;
    if (clear_now) begin
      // Hardware clear returns the transfer phase and captured data to reset values; mode and clear flag still follow the pins
      phase_next = PH_IDLE; // R08
      wr_is_cmd_next = 1'b0;
      wr_data_next = '0;
      rd_was_data_next = 1'b0;
      dout_next = hbad_pkg::BUS_IDLE;
    end else begin
      case (phase_reg)
        PH_IDLE: begin
          if (kind_now == hbad_pkg::XFER_STATUS_RD || kind_now == hbad_pkg::XFER_DATA_RD) begin
            phase_next = PH_READ;
          end else if (kind_now == hbad_pkg::XFER_PARAM_WR || kind_now == hbad_pkg::XFER_CMD_WR) begin
            phase_next = PH_WRITE;
          end
        end
        PH_READ: begin
          if (kind_now == hbad_pkg::XFER_STATUS_RD || kind_now == hbad_pkg::XFER_DATA_RD) begin
            // Bus is driven only while the read is still being asserted
            doe_next = 1'b1; // R04 R05
            dout_next = (kind_now == hbad_pkg::XFER_DATA_RD) ? i_rd_data : i_status; // R01
          end else begin
            phase_next = PH_IDLE;
            rd_ack_next = 1'b1;
            rd_was_data_next = (kind_prev == hbad_pkg::XFER_DATA_RD);
          end
        end
        PH_WRITE: begin
          if (kind_now != kind_prev) begin
            // Trailing edge: take data and select from the last sample inside the strobe
            phase_next = PH_IDLE;
            wr_valid_next = 1'b1; // R06 R10 R05
            wr_is_cmd_next = (kind_prev == hbad_pkg::XFER_CMD_WR); // R02 R10
            wr_data_next = prev_reg[P_DAT +: DATA_W]; // R10
          end
        end
        default: begin
          phase_next = PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_reg <= PH_IDLE;
      wr_valid_reg <= 1'b0;
      wr_is_cmd_reg <= 1'b0;
      wr_data_reg <= '0;
      rd_ack_reg <= 1'b0;
      rd_was_data_reg <= 1'b0;
      dout_reg <= hbad_pkg::BUS_IDLE;
      doe_reg <= 1'b0;
      clear_reg <= 1'b0;
      mode_reg <= 2'h0;
    end else if (i_ce) begin
      phase_reg <= phase_next;
      wr_valid_reg <= wr_valid_next;
      wr_is_cmd_reg <= wr_is_cmd_next;
      wr_data_reg <= wr_data_next;
      rd_ack_reg <= rd_ack_next;
      rd_was_data_reg <= rd_was_data_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      clear_reg <= clear_now; // R08
      mode_reg <= mode_next;
    end
  end

  assign bus.dev_data_out = dout_reg;
  assign bus.dev_data_oe = doe_reg;
  assign o_wr_valid = wr_valid_reg;
  assign o_wr_is_cmd = wr_is_cmd_reg;
  assign o_wr_data = wr_data_reg;
  assign o_rd_ack = rd_ack_reg;
  assign o_rd_was_data = rd_was_data_reg;
  assign o_hw_clear = clear_reg;
  assign o_mode = mode_reg;
endmodule
`default_nettype wire

//--- core/hbad_host.sv
// Host end: turns user requests into pin-level host bus cycles
`default_nettype none
module hbad_host #(
  parameter int DATA_W = hbad_pkg::DATA_W
) (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Pins
  hbad_if.host bus,
  // Configuration
  input wire logic i_enable_mode,
  // Requests
  input wire logic i_req,
  input wire logic i_req_read,
  input wire logic i_req_dts,
  input wire logic [DATA_W-1:0] i_req_data,
  input wire logic i_clear_req,
  // Answers
  output logic o_busy,
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data
);
  if (DATA_W != hbad_pkg::DATA_W) begin : g_bad_width
    $error("hbad_host: DATA_W must match the pin bus width");
  end

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_SETUP = 3'h1,
    H_STROBE = 3'h2,
    H_HOLD = 3'h3,
    H_CLEAR = 3'h4
  } hbad_hstate_type;

  // ----------------------------------------------------------------
  // Read-back synchroniser
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rsync1_reg;
  logic [DATA_W-1:0] rsync2_reg;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rsync1_reg <= hbad_pkg::BUS_IDLE;
      rsync2_reg <= hbad_pkg::BUS_IDLE;
    end else if (i_ce) begin
      rsync1_reg <= bus.data_bus;
      rsync2_reg <= rsync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  hbad_hstate_type st_reg, st_next;
  logic [hbad_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic mode_e_reg, mode_e_next;
  logic read_reg, read_next;
  logic cs_n_reg, cs_n_next;
  logic dts_reg, dts_next;
  logic rde_reg, rde_next;
  logic wrw_reg, wrw_next;
  logic clr_n_reg, clr_n_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic doe_reg, doe_next;
  logic busy_reg, busy_next;
  logic rv_reg, rv_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    mode_e_next = mode_e_reg;
    read_next = read_reg;
    cs_n_next = cs_n_reg;
    dts_next = dts_reg;
    rde_next = rde_reg;
    wrw_next = wrw_reg;
    clr_n_next = 1'b1;
    dout_next = dout_reg;
    doe_next = doe_reg;
    busy_next = 1'b1;
    rv_next = 1'b0;
    rdata_next = rdata_reg;
    case (st_reg)
      H_IDLE: begin
        busy_next = 1'b0;
        mode_e_next = i_enable_mode; // R09
        rde_next = i_enable_mode ? hbad_pkg::ENABLE_IDLE : hbad_pkg::STROBE_IDLE_N;
        wrw_next = i_enable_mode ? hbad_pkg::RW_READ : hbad_pkg::STROBE_IDLE_N;
        if (i_clear_req) begin
          st_next = H_CLEAR;
          cnt_next = hbad_pkg::CNT_W'(hbad_pkg::CLEAR_CYC - 1);
          clr_n_next = 1'b0; // R08
          busy_next = 1'b1;
        end else if (i_req) begin
          st_next = H_SETUP;
          cnt_next = hbad_pkg::CNT_W'(hbad_pkg::SETUP_CYC - 1);
          read_next = i_req_read;
          cs_n_next = 1'b0; // R07
          dts_next = i_req_dts; // R01 R02
          dout_next = i_req_data;
          doe_next = !i_req_read;
          busy_next = 1'b1;
          if (i_enable_mode) begin
            wrw_next = i_req_read; // R03
          end
        end
      end
      H_SETUP: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == '0) begin
          st_next = H_STROBE;
          cnt_next = hbad_pkg::CNT_W'(hbad_pkg::STROBE_CYC - 1);
          if (mode_e_reg) begin
            rde_next = 1'b1; // R05
          end else if (read_reg) begin
            rde_next = 1'b0; // R04
          end else begin
            wrw_next = 1'b0; // R06
          end
        end
      end
      H_STROBE: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == '0) begin
          // Released strobe gives the edge the device latches on: the rising write edge in strobe mode, the falling enable edge in enable mode
          st_next = H_HOLD;
          cnt_next = hbad_pkg::CNT_W'(hbad_pkg::HOLD_CYC - 1);
          rde_next = mode_e_reg ? hbad_pkg::ENABLE_IDLE : hbad_pkg::STROBE_IDLE_N; // R10
          wrw_next = mode_e_reg ? wrw_reg : hbad_pkg::STROBE_IDLE_N;
          if (read_reg) begin
            rv_next = 1'b1;
            rdata_next = rsync2_reg;
          end
        end
      end
      H_HOLD: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == '0) begin
          st_next = H_IDLE;
          cs_n_next = 1'b1;
          doe_next = 1'b0;
          wrw_next = mode_e_reg ? hbad_pkg::RW_READ : hbad_pkg::STROBE_IDLE_N;
          busy_next = 1'b0;
        end
      end
      H_CLEAR: begin
        cnt_next = cnt_reg - 1'b1;
        clr_n_next = 1'b0;
        if (cnt_reg == '0) begin
          st_next = H_IDLE;
          clr_n_next = 1'b1;
          busy_next = 1'b0;
        end
      end
      default: begin
        st_next = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= H_IDLE;
      cnt_reg <= '0;
      mode_e_reg <= 1'b0;
      read_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      dts_reg <= hbad_pkg::DTS_LOW;
      rde_reg <= hbad_pkg::STROBE_IDLE_N;
      wrw_reg <= hbad_pkg::STROBE_IDLE_N;
      clr_n_reg <= 1'b1;
      dout_reg <= hbad_pkg::BUS_IDLE;
      doe_reg <= 1'b0;
      busy_reg <= 1'b0;
      rv_reg <= 1'b0;
      rdata_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      mode_e_reg <= mode_e_next;
      read_reg <= read_next;
      cs_n_reg <= cs_n_next;
      dts_reg <= dts_next;
      rde_reg <= rde_next;
      wrw_reg <= wrw_next;
      clr_n_reg <= clr_n_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      busy_reg <= busy_next;
      rv_reg <= rv_next;
      rdata_reg <= rdata_next;
    end
  end

  assign bus.chip_select_n = cs_n_reg;
  assign bus.data_type_select = dts_reg;
  assign bus.read_or_enable = rde_reg;
  assign bus.write_or_rw = wrw_reg;
  assign bus.host_family_select_a = mode_e_reg; // R09
  assign bus.host_family_select_b = 1'b0; // R09
  assign bus.hardware_clear_n = clr_n_reg;
  assign bus.host_data_out = dout_reg;
  assign bus.host_data_oe = doe_reg;
  assign o_busy = busy_reg;
  assign o_rd_valid = rv_reg;
  assign o_rd_data = rdata_reg;
endmodule
`default_nettype wire

//--- core/hbad_if.sv
// Pin-level carrier between the host end and the device end
`default_nettype none
interface hbad_if;
  logic chip_select_n;
  logic data_type_select;
  logic read_or_enable;
  logic write_or_rw;
  logic host_family_select_a;
  logic host_family_select_b;
  logic hardware_clear_n;
  logic [hbad_pkg::DATA_W-1:0] host_data_out;
  logic host_data_oe;
  logic [hbad_pkg::DATA_W-1:0] dev_data_out;
  logic dev_data_oe;
  wire logic [hbad_pkg::DATA_W-1:0] data_bus;

  // Resolved bus level; an undriven bus floats high
  assign data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : hbad_pkg::BUS_IDLE);

  modport device (
    input chip_select_n, data_type_select, read_or_enable, write_or_rw,
    input host_family_select_a, host_family_select_b, hardware_clear_n, data_bus,
    output dev_data_out, dev_data_oe
  );
  modport host (
    output chip_select_n, data_type_select, read_or_enable, write_or_rw,
    output host_family_select_a, host_family_select_b, hardware_clear_n,
    output host_data_out, host_data_oe,
    input data_bus
  );
endinterface
`default_nettype wire

//--- core/hbad_pkg.sv
// Shared constants and types for the host bus access decode block
`default_nettype none
package hbad_pkg;
  // ----------------------------------------------------------------
  // Widths and pin defaults
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam logic [DATA_W-1:0] BUS_IDLE = 8'hFF;
  localparam logic STROBE_IDLE_N = 1'h1;
  localparam logic ENABLE_IDLE = 1'h0;
  localparam logic RW_READ = 1'h1;
  localparam logic DTS_LOW = 1'h0;
  localparam logic DTS_HIGH = 1'h1;
  // ----------------------------------------------------------------
  // Host-side timing, in ns, and derived cycle counts
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETUP_NS = 16;
  localparam int STROBE_NS = 80;
  localparam int HOLD_NS = 16;
  localparam int CLEAR_NS = 80;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_CYC = (CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 5;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STROBE = 2'h0,
    MODE_ENABLE = 2'h1,
    MODE_NONE = 2'h2
  } hbad_mode_type;
  typedef enum logic [2:0] {
    XFER_NONE = 3'h0,
    XFER_STATUS_RD = 3'h1,
    XFER_DATA_RD = 3'h2,
    XFER_PARAM_WR = 3'h3,
    XFER_CMD_WR = 3'h4
  } hbad_xfer_type;
endpackage
`default_nettype wire

//--- verification/hbad_assertions.sv
// Pin-level checks between the host end and the device end
`default_nettype none
module hbad_assertions (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Pins
  input wire logic chip_select_n,
  input wire logic data_type_select,
  input wire logic read_or_enable,
  input wire logic write_or_rw,
  input wire logic host_family_select_a,
  input wire logic host_family_select_b,
  input wire logic hardware_clear_n,
  input wire logic [hbad_pkg::DATA_W-1:0] host_data_out,
  input wire logic host_data_oe,
  input wire logic [hbad_pkg::DATA_W-1:0] dev_data_out,
  input wire logic dev_data_oe,
  input wire logic [hbad_pkg::DATA_W-1:0] data_bus
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------------------------------
  // Device drivers
  // ----------------------------------------------------------------
  AST_OE_CAUSE: assert property (dev_data_oe |-> !$past(chip_select_n, 4) && $past(write_or_rw, 4)
    && ($past(read_or_enable, 4) == host_family_select_a)) else $error("device drove bus without a read");
  AST_OE_RISE: assert property ($fell(read_or_enable) && !host_family_select_a && !chip_select_n
    && write_or_rw |-> ##4 dev_data_oe) else $error("read strobe did not enable drivers");
  AST_OE_DROP: assert property ($rose(read_or_enable) && !host_family_select_a && dev_data_oe
    |-> dev_data_oe [*3] ##1 !dev_data_oe) else $error("drivers not released after read strobe");
  AST_ENABLE_OE: assert property ($rose(read_or_enable) && host_family_select_a && write_or_rw
    && !chip_select_n |-> ##4 dev_data_oe) else $error("enable clock read did not drive bus");
  AST_NO_CLASH: assert property (!(dev_data_oe && host_data_oe)) else $error("both ends drive the bus");
  // ----------------------------------------------------------------
  // Host cycles
  // ----------------------------------------------------------------
  AST_STROBE_EXCL: assert property (!host_family_select_a |-> read_or_enable || write_or_rw)
    else $error("both strobes low");
  AST_STROBE_CS: assert property (!host_family_select_a && !(read_or_enable && write_or_rw)
    |-> !chip_select_n) else $error("strobe without chip select");
  AST_SETUP: assert property ($fell(write_or_rw) && !host_family_select_a
    |-> !$past(chip_select_n, 2) && $past(chip_select_n, 3)) else $error("write setup not two cycles");
  AST_STROBE_WIDTH: assert property ($fell(write_or_rw) && !host_family_select_a
    |-> !write_or_rw [*8] ##1 !write_or_rw [*2] ##1 write_or_rw) else $error("write strobe width wrong");
  AST_WR_DATA: assert property (!host_family_select_a && !write_or_rw
    |-> host_data_oe && $stable(host_data_out) && $stable(data_type_select)) else $error("write data moved");
  AST_CLEAR_WIDTH: assert property ($fell(hardware_clear_n)
    |-> !hardware_clear_n [*8] ##1 !hardware_clear_n [*2] ##1 hardware_clear_n) else $error("clear width wrong");
  AST_SELECT_B: assert property (!host_family_select_b) else $error("second family select high");
  AST_ENABLE_RW: assert property (host_family_select_a && read_or_enable
    |-> !chip_select_n && $stable(write_or_rw)) else $error("read/write moved while enable high");
endmodule
`default_nettype wire

//--- verification/host_bus_access_decode_test.sv
// Self-checking bench joining the host end to the device end
`default_nettype none
`define HBAD_CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("BAD %s expected %h seen %h", what, exp, got); \
    end \
  end
module host_bus_access_decode_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk_sys = 1'h0;
  logic i_resetn = 1'h0;
  logic i_enable_mode = 1'h0;
  logic i_req = 1'h0;
  logic i_req_read = 1'h0;
  logic i_req_dts = 1'h0;
  logic [7:0] i_req_data = 8'h00;
  logic i_clear_req = 1'h0;
  logic [7:0] i_status = 8'h00;
  logic [7:0] i_rd_data = 8'h00;
  logic o_busy, o_rd_valid, o_wr_valid, o_wr_is_cmd, o_rd_ack, o_rd_was_data, o_hw_clear;
  logic [7:0] o_rd_data;
  logic [7:0] o_wr_data;
  logic [1:0] o_mode;
  int err_total = 0;
  int comparisons = 0;
  always #4 i_clk_sys = ~i_clk_sys;
  hbad_if i_hbad_if ();
  hbad_host i_hbad_host (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_ce(1'h1), .bus(i_hbad_if.host),
    .i_enable_mode(i_enable_mode), .i_req(i_req), .i_req_read(i_req_read), .i_req_dts(i_req_dts),
    .i_req_data(i_req_data), .i_clear_req(i_clear_req), .o_busy(o_busy), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data));
  hbad_device i_hbad_device (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_ce(1'h1), .bus(i_hbad_if.device),
    .i_status(i_status), .i_rd_data(i_rd_data), .o_wr_valid(o_wr_valid), .o_wr_is_cmd(o_wr_is_cmd),
    .o_wr_data(o_wr_data), .o_rd_ack(o_rd_ack), .o_rd_was_data(o_rd_was_data), .o_hw_clear(o_hw_clear),
    .o_mode(o_mode));
  hbad_assertions i_hbad_assertions (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .chip_select_n(i_hbad_if.chip_select_n), .data_type_select(i_hbad_if.data_type_select),
    .read_or_enable(i_hbad_if.read_or_enable), .write_or_rw(i_hbad_if.write_or_rw),
    .host_family_select_a(i_hbad_if.host_family_select_a), .host_family_select_b(i_hbad_if.host_family_select_b),
    .hardware_clear_n(i_hbad_if.hardware_clear_n), .host_data_out(i_hbad_if.host_data_out),
    .host_data_oe(i_hbad_if.host_data_oe), .dev_data_out(i_hbad_if.dev_data_out),
    .dev_data_oe(i_hbad_if.dev_data_oe), .data_bus(i_hbad_if.data_bus));
  // ----------------------------------------------------------------
  // Shared transfer task
  // ----------------------------------------------------------------
  // Pulses stand one cycle, so every cycle is sampled until both ends report
  task automatic run_xfer(input logic rd, input logic dts, input logic [7:0] wdata, input logic [7:0] exp_rd);
    logic got_host, got_dev, flag;
    logic [7:0] rd_seen, wr_seen;
    int n;
    got_host = !rd;
    got_dev = 1'h0;
    for (n = 0; n < 40 && o_busy !== 1'h0; n++) begin
      @(posedge i_clk_sys);
      #1;
    end
    @(posedge i_clk_sys);
    #1;
    i_req = 1'h1;
    i_req_read = rd;
    i_req_dts = dts;
    i_req_data = wdata;
    @(posedge i_clk_sys);
    #1;
    i_req = 1'h0;
    for (n = 0; n < 40 && !(got_host && got_dev); n++) begin
      @(posedge i_clk_sys);
      #1;
      if (o_rd_valid === 1'h1) begin
        got_host = 1'h1;
        rd_seen = o_rd_data;
      end
      if (o_rd_ack === 1'h1 || o_wr_valid === 1'h1) begin
        got_dev = 1'h1;
        flag = rd ? o_rd_was_data : o_wr_is_cmd;
        wr_seen = o_wr_data;
      end
    end
    `HBAD_CHK("transfer done", 1'h1, got_host & got_dev)
    // A hung transfer leaves nothing worth checking further
    if (!(got_host && got_dev)) begin
      final_report();
    end
    if (rd) begin
      `HBAD_CHK("read data", exp_rd, rd_seen)
      `HBAD_CHK("read kind", dts, flag)
    end else begin
      `HBAD_CHK("write data", wdata, wr_seen)
      `HBAD_CHK("write kind", dts, flag)
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_scn();
    `HBAD_CHK("reset write data", 8'h00, o_wr_data)
    `HBAD_CHK("reset clear flag", 1'h0, o_hw_clear)
    `HBAD_CHK("reset mode", hbad_pkg::MODE_STROBE, o_mode)
    `HBAD_CHK("reset drivers", 1'h0, i_hbad_if.dev_data_oe)
  endtask
  task automatic strobe_scn();
    i_status = 8'h5A;
    i_rd_data = 8'hC3;
    run_xfer(1'h1, 1'h0, 8'h00, 8'h5A);
    run_xfer(1'h1, 1'h1, 8'h00, 8'hC3);
    i_status = 8'h00;
    run_xfer(1'h1, 1'h0, 8'h00, 8'h00);
    run_xfer(1'h0, 1'h0, 8'h3C, 8'h00);
    run_xfer(1'h0, 1'h1, 8'hA5, 8'h00);
  endtask
  task automatic enable_scn();
    i_enable_mode = 1'h1;
    repeat (8) @(posedge i_clk_sys);
    #1;
    `HBAD_CHK("enable mode", hbad_pkg::MODE_ENABLE, o_mode)
    i_status = 8'h81;
    i_rd_data = 8'h7E;
    run_xfer(1'h1, 1'h0, 8'h00, 8'h81);
    run_xfer(1'h1, 1'h1, 8'h00, 8'h7E);
    run_xfer(1'h0, 1'h0, 8'h18, 8'h00);
    run_xfer(1'h0, 1'h1, 8'hE7, 8'h00);
    i_enable_mode = 1'h0;
    repeat (8) @(posedge i_clk_sys);
    #1;
    `HBAD_CHK("strobe mode again", hbad_pkg::MODE_STROBE, o_mode)
  endtask
  // Clear must wipe the last write, then the port must work again
  task automatic clear_scn();
    int n;
    run_xfer(1'h0, 1'h0, 8'h96, 8'h00);
    @(posedge i_clk_sys);
    #1;
    i_clear_req = 1'h1;
    @(posedge i_clk_sys);
    #1;
    i_clear_req = 1'h0;
    for (n = 0; n < 30 && o_hw_clear !== 1'h1; n++) begin
      @(posedge i_clk_sys);
      #1;
    end
    `HBAD_CHK("clear seen", 1'h1, o_hw_clear)
    if (o_hw_clear !== 1'h1) begin
      final_report();
    end
    `HBAD_CHK("clear pin", 1'h0, i_hbad_if.hardware_clear_n)
    `HBAD_CHK("cleared write data", 8'h00, o_wr_data)
    for (n = 0; n < 40 && o_hw_clear !== 1'h0; n++) begin
      @(posedge i_clk_sys);
      #1;
    end
    `HBAD_CHK("clear ended", 1'h0, o_hw_clear)
    if (o_hw_clear !== 1'h0) begin
      final_report();
    end
    run_xfer(1'h0, 1'h1, 8'h42, 8'h00);
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_clk_sys);
    #1;
    i_resetn = 1'h1;
    reset_scn();
    strobe_scn();
    enable_scn();
    clear_scn();
    final_report();
  end
endmodule
`default_nettype wire
